// [ccu_consts.svh]
// Register offsets, field positions and codes of the capture/compare unit
`ifndef CCU_CONSTS_SVH
`define CCU_CONSTS_SVH

`define CCU_ADDR_W        8
`define CCU_OFF_CTRL      8'h00
`define CCU_OFF_VALUE     8'h04
`define CCU_OFF_PERIOD    8'h08
`define CCU_OFF_VECTOR    8'h0c
`define CCU_OFF_PFLAG     8'h10

`define CCU_B_FLAG        0
`define CCU_B_OVF         1
`define CCU_B_OUT         2
`define CCU_B_CCI         3
`define CCU_B_IE          4
`define CCU_B_MODE_LO     5
`define CCU_B_MODE_HI     7
`define CCU_B_CAP         8
`define CCU_B_ZERO        9
`define CCU_B_SCCI        10
`define CCU_B_SCS         11
`define CCU_B_SRC_LO      12
`define CCU_B_SRC_HI      13
`define CCU_B_EDGE_LO     14
`define CCU_B_EDGE_HI     15

`define CCU_CTRL_RESET    16'h0000
`define CCU_VALUE_RESET   16'h0000
`define CCU_PERIOD_RESET  16'h0000

`define CCU_VEC_NONE      4'h0
`define CCU_VEC_CH1       4'h2
`define CCU_VEC_CH2       4'h4
`define CCU_VEC_CH3       4'h6
`define CCU_VEC_CH4       4'h8
`define CCU_VEC_OVF       4'ha

`define CCU_HTRANS_NONSEQ 2'b10

`endif

// [ccu_pkg.sv]
// Types shared by the capture/compare unit
package ccu_pkg;
    typedef logic [15:0] ccu_count_t;
    typedef enum logic [2:0] {
        CCU_OUT_BIT,
        CCU_OUT_SET,
        CCU_OUT_TOG_RST,
        CCU_OUT_SET_RST,
        CCU_OUT_TOG,
        CCU_OUT_RST,
        CCU_OUT_TOG_SET,
        CCU_OUT_RST_SET
    } ccu_out_mode_e;
    typedef enum logic [1:0] {
        CCU_EDGE_OFF,
        CCU_EDGE_RISE,
        CCU_EDGE_FALL,
        CCU_EDGE_BOTH
    } ccu_edge_e;
    typedef enum logic [1:0] {
        CCU_SRC_A,
        CCU_SRC_B,
        CCU_SRC_GND,
        CCU_SRC_VCC
    } ccu_src_e;
endpackage

// [ccu_unit.sv]
// Capture/compare channel with channel-0 flag and shared vector
//
// Behaviour
// RULE1: Mode 0 output follows control output bit
// RULE2: Modes 1,4,5: own equal sets, toggles, resets
// RULE3: Modes 2,6: toggle; channel 0 resets/sets
// RULE4: Mode 3 set/reset; mode 7 reset/set
// RULE5: Non-zero modes update on timer clock edge
// RULE6: Bit 8 selects compare or capture
// RULE7: Bit 9 reads zero always
// RULE8: Bit 10 latches input on equal event
// RULE9: Bit 11 selects synchronised capture input
// RULE10: Bits 12-13 pick A, B, ground, high
// RULE11: Bits 14-15 pick capture edge
// RULE12: Software avoids capture while switching to capture
// RULE13: Channel-0 flag sets on count equal compare
// RULE14: Channel 0 has own highest-priority vector
// RULE15: Two vectors: channel 0 and shared
// RULE16: Bits 5-7 select output mode
// RULE17: Channel-0 flag clears when request serviced
// RULE18: Shared vector gives even code of highest
// RULE19: Vector access clears only highest flag
// RULE20: Capture copies count and sets flag
// RULE21: Software capture by toggling ground/high source
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`include "ccu_consts.svh"

module ccu_unit (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire ccu_pkg::ccu_count_t timer_count,
    input  wire logic               timer_tick,
    input  wire logic               capture_input_a,
    input  wire logic               capture_input_b,
    input  wire logic [2:0]         other_channel_set,
    input  wire logic               timer_overflow_set,
    input  wire logic               period_irq_ack,
    output logic                    channel_output,
    output logic                    period_irq,
    output logic                    shared_irq
);
    import ccu_pkg::*;

    // Reset image of the control word; a literal cannot be bit-selected
    localparam logic [15:0] CTRL_RST = `CCU_CTRL_RESET;

    // Bus address phase capture
    logic                   dp_valid_reg;
    logic                   dp_write_reg;
    logic [`CCU_ADDR_W-1:0] dp_addr_reg;
    wire                    ap_take;
    assign ap_take = hsel & hready & (htrans == `CCU_HTRANS_NONSEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg  <= '0;
        end else begin
            dp_valid_reg <= ap_take;
            dp_write_reg <= hwrite;
            dp_addr_reg  <= haddr[`CCU_ADDR_W-1:0];
        end
    end

    // Zero wait states; every access answers OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    wire sel_ctrl;
    wire sel_value;
    wire sel_period;
    wire sel_vector;
    wire sel_pflag;
    assign sel_ctrl   = dp_valid_reg & (dp_addr_reg == `CCU_OFF_CTRL);
    assign sel_value  = dp_valid_reg & (dp_addr_reg == `CCU_OFF_VALUE);
    assign sel_period = dp_valid_reg & (dp_addr_reg == `CCU_OFF_PERIOD);
    assign sel_vector = dp_valid_reg & (dp_addr_reg == `CCU_OFF_VECTOR);
    assign sel_pflag  = dp_valid_reg & (dp_addr_reg == `CCU_OFF_PFLAG);

    wire wr_ctrl;
    wire wr_value;
    wire wr_period;
    wire wr_pflag;
    assign wr_ctrl   = sel_ctrl & dp_write_reg;
    assign wr_value  = sel_value & dp_write_reg;
    assign wr_period = sel_period & dp_write_reg;
    assign wr_pflag  = sel_pflag & dp_write_reg;

    // Control fields
    logic            flag_reg;
    logic            ovf_reg;
    logic            out_bit_reg;
    logic            ie_reg;
    ccu_out_mode_e   mode_reg;
    logic            cap_reg;
    logic            scci_reg;
    logic            scs_reg;
    ccu_src_e        src_reg;
    ccu_edge_e       edge_reg;
    logic [15:0]     value_reg;
    logic [15:0]     period_reg;
    logic            pflag_reg;
    logic [2:0]      other_flag_reg;
    logic            tovf_flag_reg;
    logic            out_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_bit_reg <= CTRL_RST[`CCU_B_OUT];
            ie_reg      <= CTRL_RST[`CCU_B_IE];
            mode_reg    <= CCU_OUT_BIT;
            cap_reg     <= CTRL_RST[`CCU_B_CAP];
            scs_reg     <= CTRL_RST[`CCU_B_SCS];
            src_reg     <= CCU_SRC_A;
            edge_reg    <= CCU_EDGE_OFF;
            period_reg  <= `CCU_PERIOD_RESET;
        end else if (wr_ctrl) begin
            out_bit_reg <= hwdata[`CCU_B_OUT];
            ie_reg      <= hwdata[`CCU_B_IE];
            mode_reg    <= ccu_out_mode_e'(
                hwdata[`CCU_B_MODE_HI:`CCU_B_MODE_LO]); // RULE16
            cap_reg     <= hwdata[`CCU_B_CAP]; // RULE6
            scs_reg     <= hwdata[`CCU_B_SCS]; // RULE9
            src_reg     <= ccu_src_e'(
                hwdata[`CCU_B_SRC_HI:`CCU_B_SRC_LO]); // RULE10
            edge_reg    <= ccu_edge_e'(
                hwdata[`CCU_B_EDGE_HI:`CCU_B_EDGE_LO]); // RULE11
        end else if (wr_period) begin
            period_reg  <= hwdata[15:0];
        end
    end

    // Capture source, ground and high included for software capture
    logic cci;
    always_comb begin
        case (src_reg)
            CCU_SRC_A:   cci = capture_input_a; // RULE10
            CCU_SRC_B:   cci = capture_input_b;
            CCU_SRC_GND: cci = 1'b0;
            default:     cci = 1'b1; // RULE21
        endcase
    end

    // Two-stage synchroniser; first stage feeds only the second
    logic sync1_reg;
    logic sync2_reg;
    logic cap_prev_reg;
    wire  cap_src;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg    <= 1'b0;
            sync2_reg    <= 1'b0;
            cap_prev_reg <= 1'b0;
        end else begin
            sync1_reg    <= cci;
            sync2_reg    <= sync1_reg;
            cap_prev_reg <= cap_src;
        end
    end

    assign cap_src = scs_reg ? sync2_reg : cci; // RULE9

    wire rise;
    wire fall;
    wire cap_event;
    assign rise = cap_src & ~cap_prev_reg;
    assign fall = ~cap_src & cap_prev_reg;
    assign cap_event = cap_reg & (
        ((edge_reg == CCU_EDGE_RISE) & rise) |
        ((edge_reg == CCU_EDGE_FALL) & fall) |
        ((edge_reg == CCU_EDGE_BOTH) & (rise | fall))); // RULE11

    // Equal events qualified by the timer clock enable
    wire chan_equal;
    wire period_equal;
    assign chan_equal = timer_tick & ~cap_reg &
                        (timer_count == value_reg);
    assign period_equal = timer_tick & (timer_count == period_reg);

    // Capture wins over a software write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value_reg <= `CCU_VALUE_RESET;
        end else if (cap_event) begin
            value_reg <= timer_count; // RULE20
        end else if (wr_value) begin
            value_reg <= hwdata[15:0];
        end
    end

    // Clocked stand-in for the transparent latch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scci_reg <= CTRL_RST[`CCU_B_SCCI];
        end else if (chan_equal) begin
            scci_reg <= cci; // RULE8
        end
    end

    // Shared vector priority
    logic [3:0] vector;
    wire        ch1_pend;
    assign ch1_pend = flag_reg & ie_reg;
    always_comb begin
        if (ch1_pend) begin
            vector = `CCU_VEC_CH1; // RULE18
        end else if (other_flag_reg[0]) begin
            vector = `CCU_VEC_CH2;
        end else if (other_flag_reg[1]) begin
            vector = `CCU_VEC_CH3;
        end else if (other_flag_reg[2]) begin
            vector = `CCU_VEC_CH4;
        end else if (tovf_flag_reg) begin
            vector = `CCU_VEC_OVF;
        end else begin
            vector = `CCU_VEC_NONE;
        end
    end

    // Read or write of the vector clears its top flag only
    wire clr_ch1;
    wire clr_ch2;
    wire clr_ch3;
    wire clr_ch4;
    wire clr_ovf;
    assign clr_ch1 = sel_vector & (vector == `CCU_VEC_CH1); // RULE19
    assign clr_ch2 = sel_vector & (vector == `CCU_VEC_CH2);
    assign clr_ch3 = sel_vector & (vector == `CCU_VEC_CH3);
    assign clr_ch4 = sel_vector & (vector == `CCU_VEC_CH4);
    assign clr_ovf = sel_vector & (vector == `CCU_VEC_OVF);

    wire ch1_set;
    assign ch1_set = chan_equal | cap_event; // RULE20

    // Hardware set wins over every clear
    wire flag_next;
    wire ovf_next;
    assign flag_next = ch1_set |
        (wr_ctrl ? hwdata[`CCU_B_FLAG] : (flag_reg & ~clr_ch1));
    assign ovf_next = (cap_event & flag_reg) |
        (wr_ctrl ? hwdata[`CCU_B_OVF] : ovf_reg);

    wire [2:0] other_next;
    assign other_next = other_channel_set |
        (other_flag_reg & ~{clr_ch4, clr_ch3, clr_ch2});

    wire tovf_next;
    assign tovf_next = timer_overflow_set | (tovf_flag_reg & ~clr_ovf);

    // Service acknowledge or software write clears; equality sets
    wire pflag_next;
    assign pflag_next = period_equal | // RULE13
        (wr_pflag ? hwdata[0] : (pflag_reg & ~period_irq_ack)); // RULE17

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_reg       <= CTRL_RST[`CCU_B_FLAG];
            ovf_reg        <= CTRL_RST[`CCU_B_OVF];
            other_flag_reg <= 3'h0;
            tovf_flag_reg  <= 1'b0;
            pflag_reg      <= 1'b0;
        end else begin
            flag_reg       <= flag_next;
            ovf_reg        <= ovf_next;
            other_flag_reg <= other_next;
            tovf_flag_reg  <= tovf_next;
            pflag_reg      <= pflag_next;
        end
    end

    // Output unit
    logic out_next;
    always_comb begin
        out_next = out_reg;
        case (mode_reg)
            CCU_OUT_SET: begin
                if (chan_equal) out_next = 1'b1; // RULE2
            end
            CCU_OUT_TOG: begin
                if (chan_equal) out_next = ~out_reg; // RULE2
            end
            CCU_OUT_RST: begin
                if (chan_equal) out_next = 1'b0; // RULE2
            end
            CCU_OUT_TOG_RST: begin
                if (chan_equal) out_next = ~out_reg; // RULE3
                else if (period_equal) out_next = 1'b0;
            end
            CCU_OUT_TOG_SET: begin
                if (chan_equal) out_next = ~out_reg; // RULE3
                else if (period_equal) out_next = 1'b1;
            end
            CCU_OUT_SET_RST: begin
                if (chan_equal) out_next = 1'b1; // RULE4
                else if (period_equal) out_next = 1'b0;
            end
            CCU_OUT_RST_SET: begin
                if (chan_equal) out_next = 1'b0; // RULE4
                else if (period_equal) out_next = 1'b1;
            end
            default: begin
                out_next = out_bit_reg;
            end
        endcase
    end

    // Updates only on a timer clock edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_reg <= 1'b0;
        end else if (timer_tick) begin
            out_reg <= out_next; // RULE5
        end
    end

    // Mode 0 bypasses the timer clock
    assign channel_output = (mode_reg == CCU_OUT_BIT) ?
                            out_bit_reg : out_reg; // RULE1

    // Two separate requests; channel 0 outranks the shared one
    assign period_irq = pflag_reg; // RULE14
    assign shared_irq = (vector != `CCU_VEC_NONE); // RULE15

    // Read mux
    logic [15:0] ctrl_view;
    always_comb begin
        ctrl_view = 16'h0000;
        ctrl_view[`CCU_B_FLAG] = flag_reg;
        ctrl_view[`CCU_B_OVF]  = ovf_reg;
        ctrl_view[`CCU_B_OUT]  = out_bit_reg;
        ctrl_view[`CCU_B_CCI]  = cci;
        ctrl_view[`CCU_B_IE]   = ie_reg;
        ctrl_view[`CCU_B_MODE_HI:`CCU_B_MODE_LO] = mode_reg;
        ctrl_view[`CCU_B_CAP]  = cap_reg;
        ctrl_view[`CCU_B_ZERO] = 1'b0; // RULE7
        ctrl_view[`CCU_B_SCCI] = scci_reg; // RULE8
        ctrl_view[`CCU_B_SCS]  = scs_reg;
        ctrl_view[`CCU_B_SRC_HI:`CCU_B_SRC_LO] = src_reg;
        ctrl_view[`CCU_B_EDGE_HI:`CCU_B_EDGE_LO] = edge_reg;
    end

    wire rd;
    assign rd = dp_valid_reg & ~dp_write_reg;

    always_comb begin
        hrdata = 32'h0000_0000;
        if (rd & sel_ctrl) begin
            hrdata = {16'h0000, ctrl_view};
        end else if (rd & sel_value) begin
            hrdata = {16'h0000, value_reg};
        end else if (rd & sel_period) begin
            hrdata = {16'h0000, period_reg};
        end else if (rd & sel_vector) begin
            hrdata = {28'h000_0000, vector};
        end else if (rd & sel_pflag) begin
            hrdata = {31'h0000_0000, pflag_reg};
        end
    end
endmodule

// [ccu_unit_sva.sv]
// Port checker of the capture/compare unit
`timescale 1ns/1ns
module ccu_unit_sva
(
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    input wire logic [31:0]         hrdata,
    input wire ccu_pkg::ccu_count_t timer_count,
    input wire logic                timer_tick,
    input wire logic                timer_overflow_set,
    input wire logic                period_irq_ack,
    input wire logic                channel_output,
    input wire logic                period_irq,
    input wire logic                shared_irq
);
    import ccu_pkg::*;
    logic        dp_v_reg;
    logic        dp_w_reg;
    logic [7:0]  dp_a_reg;
    logic [15:0] ctrl_reg;
    logic [15:0] val_reg;
    logic [15:0] per_reg;
    // Shadows follow software writes only; guards skip write edges
    wire         wr_now = dp_v_reg && dp_w_reg;
    wire         peq_raw = timer_tick && timer_count == per_reg;
    wire         peq = peq_raw && !wr_now;
    wire         eq = timer_tick && timer_count == val_reg && !ctrl_reg[8]
                      && !wr_now;
    wire [2:0]   mode = ctrl_reg[7:5];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_v_reg <= 1'b0;
            dp_w_reg <= 1'b0;
            dp_a_reg <= 8'h00;
            ctrl_reg <= 16'h0000;
            val_reg <= 16'h0000;
            per_reg <= 16'h0000;
        end else begin
            dp_v_reg <= hsel && hready && htrans == 2'b10;
            dp_w_reg <= hwrite;
            dp_a_reg <= haddr[7:0];
            if (wr_now && dp_a_reg == 8'h00) ctrl_reg <= hwdata[15:0];
            if (wr_now && dp_a_reg == 8'h04) val_reg <= hwdata[15:0];
            if (wr_now && dp_a_reg == 8'h08) per_reg <= hwdata[15:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    mode0_out_a: assert property (
        mode == 3'h0 |-> channel_output == ctrl_reg[2])
        else $error("mode 0 output differs from bit");
    eq_set_a: assert property (
        eq && mode inside {3'h1, 3'h3} |=> channel_output)
        else $error("equal event did not set output");
    eq_rst_a: assert property (
        eq && mode inside {3'h5, 3'h7} |=> !channel_output)
        else $error("equal event did not reset output");
    eq_tog_a: assert property (
        eq && mode inside {3'h2, 3'h4, 3'h6}
        |=> channel_output != $past(channel_output))
        else $error("equal event did not toggle output");
    period_out_a: assert property (
        peq && !eq && mode inside {3'h2, 3'h3, 3'h6, 3'h7}
        |=> channel_output == $past(ctrl_reg[7]))
        else $error("period event gave wrong output");
    tick_hold_a: assert property (
        mode != 3'h0 && !timer_tick && !wr_now
        |=> $stable(channel_output))
        else $error("output moved without timer tick");
    zero_bit_a: assert property (
        dp_v_reg && !dp_w_reg && dp_a_reg == 8'h00
        |-> hrdata[9] == 1'b0 && hrdata[31:16] == 16'h0000)
        else $error("control read shows nonzero fixed bits");
    pflag_set_a: assert property (peq |=> period_irq)
        else $error("period flag not set");
    pflag_ack_a: assert property (
        period_irq_ack && !peq_raw && !wr_now
        |=> !period_irq)
        else $error("period flag not cleared by ack");
    ovf_irq_a: assert property (
        timer_overflow_set && !dp_v_reg |=> shared_irq)
        else $error("overflow did not raise shared request");
endmodule

bind ccu_unit ccu_unit_sva ccu_unit_sva_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .timer_count(timer_count), .timer_tick(timer_tick),
    .timer_overflow_set(timer_overflow_set),
    .period_irq_ack(period_irq_ack), .channel_output(channel_output),
    .period_irq(period_irq), .shared_irq(shared_irq)
);

// [ccu_timer_model.sv]
// Shared timer counter model: up count to top, tick, overflow pulse
`timescale 1ns/1ns
module ccu_timer_model (
    input  wire logic           hclk,
    input  wire logic           hresetn,
    input  wire logic           run,
    input  wire logic [15:0]    top,
    output ccu_pkg::ccu_count_t timer_count,
    output logic                timer_tick,
    output logic                timer_overflow_set
);
    import ccu_pkg::*;
    // Tick every second cycle so holding between ticks is exercised
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_tick <= 1'b0;
            timer_count <= 16'h0000;
            timer_overflow_set <= 1'b0;
        end else begin
            timer_tick <= run && !timer_tick;
            timer_overflow_set <= timer_tick && timer_count == top;
            if (timer_tick) begin
                timer_count <= (timer_count == top) ? 16'h0000
                                                    : timer_count + 16'h0001;
            end
        end
    end
endmodule

// [ccu_unit_tb_top.sv]
// Testbench of the capture/compare unit
`timescale 1ns/1ns
`include "ccu_consts.svh"
module ccu_unit_tb_top;
    import ccu_pkg::*;
    localparam logic [7:0]  LOW_EXP = 8'hc2;
    localparam logic [7:0]  MID_EXP = 8'h1e;
    localparam logic [31:0] VEC_EXP [6] = '{32'h2, 32'h4, 32'h6, 32'h8,
                                            32'ha, 32'h0};
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        run = 1'b0;
    logic        period_irq_ack = 1'b0;
    logic        capture_input_a = 1'b0;
    logic        capture_input_b = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  other_channel_set = 3'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, timer_tick, timer_overflow_set;
    logic        channel_output, period_irq, shared_irq;
    ccu_count_t  timer_count;
    int          fails = 0;
    int          n_compared = 0;
    always #5 hclk = ~hclk;
    ccu_unit ccu_unit_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .timer_count(timer_count),
        .timer_tick(timer_tick), .capture_input_a(capture_input_a),
        .capture_input_b(capture_input_b),
        .other_channel_set(other_channel_set),
        .timer_overflow_set(timer_overflow_set),
        .period_irq_ack(period_irq_ack), .channel_output(channel_output),
        .period_irq(period_irq), .shared_irq(shared_irq));
    ccu_timer_model ccu_timer_model_i (.hclk(hclk), .hresetn(hresetn),
        .run(run), .top(16'h9), .timer_count(timer_count),
        .timer_tick(timer_tick), .timer_overflow_set(timer_overflow_set));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // No wait limit of its own; only the watchdog ends a hung bus
    task automatic wait_ready();
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= `CCU_HTRANS_NONSEQ;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(r & m, e);
    endtask
    task automatic pause(input int c);
        repeat (c) @(posedge hclk);
    endtask
    task automatic wait_cnt(input logic [15:0] v);
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (timer_count !== v && n < 100);
        if (timer_count !== v) fails++;
    endtask
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // The tests need under 500 cycles; twenty times that is a hang
    initial begin
        #100000;
        fails++;
        summarize();
    end
    initial begin
        int m;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (m = 0; m < 6; m++) rdm(8'(m * 4), 32'hffffffff, 32'h0);
        wr(8'h14, 32'hffff);
        rdm(8'h14, 32'hffffffff, 32'h0);
        chk(32'(hresp), 32'h0);
        $display("reset test done");
        wr(`CCU_OFF_CTRL, 32'h0204);
        rdm(`CCU_OFF_CTRL, 32'hffff0204, 32'h0004);
        chk(32'(channel_output), 32'h1);
        wr(`CCU_OFF_CTRL, 32'h0);
        pause(1);
        chk(32'(channel_output), 32'h0);
        $display("mode 0 test done");
        wr(`CCU_OFF_PERIOD, 32'h9);
        wr(`CCU_OFF_VALUE, 32'h4);
        capture_input_a <= 1'b1;
        run <= 1'b1;
        for (m = 1; m < 8; m++) begin
            wr(`CCU_OFF_CTRL, 32'(m << 5));
            wait_cnt(16'h1);
            wait_cnt(16'h6);
            wait_cnt(16'h1);
            chk(32'(channel_output), 32'(LOW_EXP[m]));
            wait_cnt(16'h6);
            chk(32'(channel_output), 32'(MID_EXP[m]));
        end
        rdm(`CCU_OFF_CTRL, 32'h0408, 32'h0408);
        capture_input_a <= 1'b0;
        rdm(`CCU_OFF_PFLAG, 32'h1, 32'h1);
        chk(32'(period_irq), 32'h1);
        run <= 1'b0;
        pause(4);
        period_irq_ack <= 1'b1;
        @(posedge hclk);
        period_irq_ack <= 1'b0;
        pause(1);
        chk(32'(period_irq), 32'h0);
        rdm(`CCU_OFF_PFLAG, 32'h1, 32'h0);
        $display("output mode test done");
        wr(`CCU_OFF_CTRL, 32'h0011);
        other_channel_set <= 3'h7;
        @(posedge hclk);
        other_channel_set <= 3'h0;
        pause(1);
        chk(32'(shared_irq), 32'h1);
        for (m = 0; m < 6; m++) begin
            rdm(`CCU_OFF_VECTOR, 32'hf, VEC_EXP[m]);
        end
        chk(32'(shared_irq), 32'h0);
        $display("vector test done");
        wr(`CCU_OFF_CTRL, 32'he100);
        wr(`CCU_OFF_CTRL, 32'hf100);
        pause(2);
        rdm(`CCU_OFF_VALUE, 32'hffff, 32'(timer_count));
        rdm(`CCU_OFF_CTRL, 32'h000b, 32'h0009);
        wr(`CCU_OFF_CTRL, 32'he901);
        pause(1);
        // Synchronised fall reaches the edge logic two cycles late
        rdm(`CCU_OFF_CTRL, 32'h3, 32'h1);
        rdm(`CCU_OFF_CTRL, 32'h3, 32'h3);
        for (m = 0; m < 4; m++) begin
            wr(`CCU_OFF_CTRL, 32'(m << 14) | 32'h0100);
            capture_input_a <= 1'b1;
            pause(4);
            rdm(`CCU_OFF_CTRL, 32'h1, 32'(m & 1));
            wr(`CCU_OFF_CTRL, 32'(m << 14) | 32'h0100);
            capture_input_a <= 1'b0;
            pause(4);
            rdm(`CCU_OFF_CTRL, 32'h1, 32'((m >> 1) & 1));
        end
        wr(`CCU_OFF_CTRL, 32'h5100);
        capture_input_b <= 1'b1;
        pause(4);
        rdm(`CCU_OFF_CTRL, 32'h9, 32'h9);
        $display("capture test done");
        summarize();
    end
endmodule
